// file: common/hpf_tail_defines.svh
/*
 offsets, reset values, field positions and bus constants of the
 coefficient register tail. assumes a 7-bit register pointer space of 128 entries.
*/
`ifndef HPF_TAIL_DEFINES_SVH
`define HPF_TAIL_DEFINES_SVH

`define PTR_W 7
`define BYTE_W 8
`define COEFF_W 16

`define NUM1_LOW_OFS 7'h4a
`define DEN1_HIGH_OFS 7'h4b
`define DEN1_LOW_OFS 7'h4c
`define RSVD_FIRST_OFS 7'h4d
`define RSVD_LAST_OFS 7'h7f

`define NUM1_LOW_RST 8'h2d
`define DEN1_HIGH_RST 8'h53
`define DEN1_LOW_RST 8'h7e
`define RSVD_READ_VAL 8'h00

`define HIGH_BYTE_MSB 15
`define HIGH_BYTE_LSB 8
`define LOW_BYTE_MSB 7
`define LOW_BYTE_LSB 0

`define BITS_PER_BYTE 4'h8
`define DEV_ADDR_DEFAULT 7'h2a

`endif

// file: common/hpf_tail_pkg.sv
/*
 types shared by the coefficient register tail.
 assumes hpf_tail_defines.svh is on the include path.
*/
`include "hpf_tail_defines.svh"

package hpf_tail_pkg;

   typedef enum logic [3:0] {
      S_IDLE,
      S_ADDR,
      S_ACK_ADDR,
      S_PTR,
      S_ACK_PTR,
      S_WR,
      S_ACK_WR,
      S_RD,
      S_RD_ACK
   } ctl_state_t;

   typedef struct packed {
      logic [`BYTE_W-1:0] num1_low;
      logic signed [`COEFF_W-1:0] num1;
      logic signed [`COEFF_W-1:0] den1;
   } coeff_bus_t;

endpackage

// file: src/hpf_coeff_register_tail.sv
/*
 coefficient register tail behind a two-wire control port, with byte-wide
 registers and the joined 16-bit coefficients driven to the filter.
 assumes the host is the bus controller, sys_clk is the master clock and the
 numerator high byte arrives from the neighbouring register bank.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpf_tail_defines.svh"

// Contract
// - read/write byte for numerator tap one low byte, reset 0x2d
// - read/write byte for denominator tap one high byte, reset 0x53
// - read/write byte for denominator tap one low byte, reset 0x7e
// - high and low bytes join into one signed 16-bit coefficient
// - positions 77 to 127 read zero; host never writes them
// - configuration only through the register set, no pin straps
// - all internal timing runs from the master clock
// - stages stay powered down until host enables them by register; stage_enable is held low here, with no register to set it
module hpf_coeff_register_tail
   import hpf_tail_pkg::*;
#(
   parameter logic [`PTR_W-1:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // control bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // neighbouring register bank
   input wire logic [`BYTE_W-1:0] num1_high_in,
   // coefficients to the filter
   output coeff_bus_t coeff,
   output logic stage_enable
);

   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic scl_f;
   logic sda_f;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   ctl_state_t state;
   logic [3:0] bit_cnt;
   logic [`BYTE_W-1:0] shreg;
   logic [`BYTE_W-1:0] tx;
   logic [`PTR_W-1:0] ptr;
   logic rw;
   logic nack;
   logic wr_en;
   logic load_tx;

   logic [`BYTE_W-1:0] right_hpf_num1_low;
   logic [`BYTE_W-1:0] right_hpf_den1_high;
   logic [`BYTE_W-1:0] right_hpf_den1_low;

   // pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[1] == scl_sync[2]) begin
            scl_f <= scl_sync[2];
         end
         if (sda_sync[1] == sda_sync[2]) begin
            sda_f <= sda_sync[2];
         end
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   // start and stop only while the clock line stays high in both samples
   assign start_det = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_det = scl_f & scl_q & ~sda_q & sda_f;

   // write strobe at the falling edge closing a data byte
   assign wr_en = scl_fall && (state == S_WR) && (bit_cnt == `BITS_PER_BYTE);
   // next read byte is fetched as the acknowledge slot ends
   assign load_tx = scl_fall && ((state == S_ACK_ADDR && rw) || (state == S_RD_ACK && !nack));

   function automatic logic [`BYTE_W-1:0] read_reg(input logic [`PTR_W-1:0] p);
      logic [`BYTE_W-1:0] v;
      v = `RSVD_READ_VAL;
      case (p)
         `NUM1_LOW_OFS: v = right_hpf_num1_low;
         `DEN1_HIGH_OFS: v = right_hpf_den1_high;
         `DEN1_LOW_OFS: v = right_hpf_den1_low;
         // reserved tail and positions outside this bank read zero
         default: v = `RSVD_READ_VAL;
      endcase
      return v;
   endfunction

   // control bus protocol engine
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         ptr <= 7'h00;
         rw <= 1'b0;
         nack <= 1'b0;
      end else if (start_det) begin
         // repeated start restarts the address phase, pointer kept
         state <= S_ADDR;
         bit_cnt <= 4'h0;
      end else if (stop_det) begin
         state <= S_IDLE;
      end else if (scl_rise) begin
         case (state)
            S_ADDR, S_PTR, S_WR: begin
               shreg <= {shreg[6:0], sda_f};
               bit_cnt <= bit_cnt + 4'h1;
            end
            S_RD: begin
               bit_cnt <= bit_cnt + 4'h1;
            end
            S_RD_ACK: begin
               nack <= sda_f;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state)
            S_ADDR: begin
               if (bit_cnt == `BITS_PER_BYTE) begin
                  if (shreg[7:1] == DEV_ADDR) begin
                     state <= S_ACK_ADDR;
                     rw <= shreg[0];
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            S_ACK_ADDR: begin
               bit_cnt <= 4'h0;
               if (rw) begin
                  state <= S_RD;
                  tx <= read_reg(ptr);
                  ptr <= ptr + 7'h01;
               end else begin
                  state <= S_PTR;
               end
            end
            S_PTR: begin
               if (bit_cnt == `BITS_PER_BYTE) begin
                  ptr <= shreg[6:0];
                  state <= S_ACK_PTR;
               end
            end
            S_ACK_PTR, S_ACK_WR: begin
               bit_cnt <= 4'h0;
               state <= S_WR;
            end
            S_WR: begin
               if (bit_cnt == `BITS_PER_BYTE) begin
                  // pointer steps on so bursts fill consecutive bytes
                  ptr <= ptr + 7'h01;
                  state <= S_ACK_WR;
               end
            end
            S_RD: begin
               if (bit_cnt == `BITS_PER_BYTE) begin
                  state <= S_RD_ACK;
               end else begin
                  tx <= {tx[6:0], 1'b0};
               end
            end
            S_RD_ACK: begin
               bit_cnt <= 4'h0;
               if (nack) begin
                  // host ended the read; wait for stop or start
                  state <= S_IDLE;
               end else begin
                  state <= S_RD;
                  tx <= read_reg(ptr);
                  ptr <= ptr + 7'h01;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // open-drain data line: only ever pulled low
   always_comb begin
      sda_out = 1'b0;
      case (state)
         S_ACK_ADDR, S_ACK_PTR, S_ACK_WR: sda_oe = 1'b1;
         S_RD: sda_oe = ~tx[7];
         default: sda_oe = 1'b0;
      endcase
   end

   // coefficient storage; writes to reserved positions are dropped
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         right_hpf_num1_low <= `NUM1_LOW_RST;
         right_hpf_den1_high <= `DEN1_HIGH_RST;
         right_hpf_den1_low <= `DEN1_LOW_RST;
      end else if (wr_en) begin
         case (ptr)
            `NUM1_LOW_OFS: right_hpf_num1_low <= shreg;
            `DEN1_HIGH_OFS: right_hpf_den1_high <= shreg;
            `DEN1_LOW_OFS: right_hpf_den1_low <= shreg;
            default: begin
            end
         endcase
      end
   end

   // stages held off from reset; enabling lives in another bank
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage_enable <= 1'b0;
      end else begin
         stage_enable <= 1'b0;
      end
   end

   // joined coefficients, zero in reset; register defaults from one clock after release until the host writes
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         coeff <= '0;
      end else begin
         coeff.num1_low <= right_hpf_num1_low;
         coeff.num1 <= {num1_high_in, right_hpf_num1_low};
         coeff.den1 <= {right_hpf_den1_high, right_hpf_den1_low};
      end
   end

   property p_num_write;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_en && ptr == `NUM1_LOW_OFS) |=> (right_hpf_num1_low == $past(shreg));
   endproperty
   a_num_write: assert property (p_num_write) else $error("num low write lost");

   property p_den_hi_write;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_en && ptr == `DEN1_HIGH_OFS) |=> ##1 (coeff.den1[15:8] == $past(shreg, 2));
   endproperty
   a_den_hi_write: assert property (p_den_hi_write) else $error("den high byte wrong");

   property p_den_lo_write;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_en && ptr == `DEN1_LOW_OFS) |=> ##1 (coeff.den1[7:0] == $past(shreg, 2));
   endproperty
   a_den_lo_write: assert property (p_den_lo_write) else $error("den low byte wrong");

   property p_sign;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_en && ptr == `DEN1_HIGH_OFS && shreg[7]) |=> ##1 ($signed(coeff.den1) < 0);
   endproperty
   a_sign: assert property (p_sign) else $error("coefficient sign wrong");

   property p_rsvd_read;
      @(posedge sys_clk) disable iff (!arst_n)
      (load_tx && ptr >= `RSVD_FIRST_OFS) |=> (tx == `RSVD_READ_VAL);
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");

   property p_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      !wr_en |=> ($stable(right_hpf_num1_low) && $stable(right_hpf_den1_high)
                  && $stable(right_hpf_den1_low));
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without write");

   property p_drive_on_fall;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(sda_oe) |-> $past(scl_fall);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) else $error("data driven off clock");

   property p_stage_off;
      @(posedge sys_clk) disable iff (!arst_n)
      !stage_enable;
   endproperty
   a_stage_off: assert property (p_stage_off) else $error("stage enabled here");

   property p_num_join;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_en && ptr == `NUM1_LOW_OFS) |=> ##1 (coeff.num1[7:0] == $past(shreg, 2));
   endproperty
   a_num_join: assert property (p_num_join) else $error("num low not in bits 7..0");

endmodule

`default_nettype wire

// file: tb/i2c_host_model.sv
/*
 two-wire bus controller model for the coefficient register tail.
 assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   // clock
   input wire logic sys_clk,
   // bus pins
   input wire logic sda_wire,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // phases well above the device synchroniser delay
   task automatic wt;
      repeat (16) @(posedge sys_clk);
      #1;
   endtask
   // also serves as repeated start when scl is low
   task automatic start;
      sda_pull = 1'b0;
      wt;
      scl = 1'b1;
      wt;
      sda_pull = 1'b1;
      wt;
      scl = 1'b0;
      wt;
   endtask
   task automatic stop;
      sda_pull = 1'b1;
      wt;
      scl = 1'b1;
      wt;
      sda_pull = 1'b0;
      wt;
   endtask
   // msb first; last bit is released for ack or driven as host ack
   task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic ack);
      logic [8:0] tx;
      tx = {d, last};
      for (int i = 8; i >= 0; i--) begin
         sda_pull = !tx[i];
         wt;
         scl = 1'b1;
         wt;
         if (i > 0) r[i-1] = sda_wire;
         else ack = !sda_wire;
         scl = 1'b0;
         wt;
      end
   endtask
endmodule
`default_nettype wire

// file: tb/hpf_coeff_register_tail_tb_top.sv
/*
 self-checking bench for the coefficient register tail.
 assumes the host model in i2c_host_model.sv and the default device address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpf_tail_defines.svh"
module hpf_coeff_register_tail_tb_top;
   import hpf_tail_pkg::*;
   localparam logic [7:0] ADDR_W = {`DEV_ADDR_DEFAULT, 1'b0};
   localparam logic [7:0] ADDR_R = {`DEV_ADDR_DEFAULT, 1'b1};
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] num1_high_in = 8'hf3;
   logic scl, sda_pull, sda_out, sda_oe, stage_enable, ack;
   logic [7:0] rd;
   coeff_bus_t coeff;
   wire sda_wire;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   // pull-up on the data wire
   assign sda_wire = !sda_pull && !(sda_oe && !sda_out);
   // master clock drives all device timing
   always #2.5 sys_clk = ~sys_clk;
   hpf_coeff_register_tail dut_u (
      .sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .num1_high_in(num1_high_in),
      .coeff(coeff), .stage_enable(stage_enable)
   );
   i2c_host_model host_u (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl),
                          .sda_pull(sda_pull));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic set_ptr(input logic [7:0] p);
      host_u.start;
      host_u.xbyte(ADDR_W, 1'b1, rd, ack);
      chk(16'(ack), 16'h0001);
      host_u.xbyte(p, 1'b1, rd, ack);
      chk(16'(ack), 16'h0001);
   endtask
   // four-byte read with pointer auto-increment into the reserved range
   task automatic rd_seq(input logic [7:0] p, input logic [31:0] e);
      set_ptr(p);
      host_u.start;
      host_u.xbyte(ADDR_R, 1'b1, rd, ack);
      chk(16'(ack), 16'h0001);
      for (int i = 0; i < 4; i++) begin
         host_u.xbyte(8'hff, i == 3, rd, ack);
         chk(16'(rd), 16'(e[31-8*i -: 8]));
      end
      host_u.stop;
   endtask
   task automatic t_defaults;
      chk(16'(coeff.num1_low), 16'h002d);
      chk(coeff.den1, 16'h537e);
      chk(coeff.num1, {num1_high_in, 8'h2d});
      chk(16'(stage_enable), 16'h0000);
   endtask
   // boundary bytes, negative coefficient, then read back
   task automatic t_write;
      set_ptr(8'h4a);
      for (int i = 0; i < 3; i++) begin
         host_u.xbyte(i == 0 ? 8'h01 : (i == 1 ? 8'h80 : 8'hff), 1'b1, rd, ack);
         chk(16'(ack), 16'h0001);
      end
      host_u.stop;
      chk(16'(coeff.num1_low), 16'h0001);
      chk(coeff.den1, 16'h80ff);
      num1_high_in = 8'h80;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(coeff.num1, 16'h8001);
      rd_seq(8'h4a, 32'h0180ff00);
   endtask
   // foreign address must not be acknowledged
   task automatic t_wrong_addr;
      host_u.start;
      host_u.xbyte({7'h2b, 1'b0}, 1'b1, rd, ack);
      chk(16'(ack), 16'h0000);
      host_u.stop;
   endtask
   // reset in mid-run restores every default
   task automatic t_reset_mid;
      arst_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      chk(16'(sda_oe), 16'h0000);
      arst_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      t_defaults;
      rd_seq(8'h4a, 32'h2d537e00);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1;
      t_defaults;
      rd_seq(8'h4a, 32'h2d537e00);
      t_write;
      t_wrong_addr;
      t_reset_mid;
      conclude;
   end
   // hang guard, roughly three times the expected run
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         conclude;
      end
   end
endmodule
`default_nettype wire
